// ### mec_pkg.sv
// constants and types of the maintenance, error count and mask registers
`default_nettype none
package mec_pkg;
   localparam logic [7:0] MEC_OFS_DEACT_LEN = 8'h0E;
   localparam logic [7:0] MEC_OFS_DEACT = 8'h11;
   localparam logic [7:0] MEC_OFS_CTRL = 8'h12;
   localparam logic [7:0] MEC_OFS_MASK0 = 8'h13;
   localparam logic [7:0] MEC_OFS_MASK1 = 8'h14;
   localparam logic [7:0] MEC_OFS_CNT_LO = 8'h18;
   localparam logic [7:0] MEC_OFS_CNT_HI = 8'h19;
   localparam logic [7:0] MEC_RST_DEACT = 8'h09;
   localparam logic [1:0] MEC_RST_DEACT_LEN = 2'h1;
   localparam logic [7:0] MEC_RST_CTRL = 8'h00;
   localparam logic [7:0] MEC_RST_MASK = 8'hFF;
   localparam logic [7:0] MEC_CTRL_WMASK = 8'h7F;
   localparam int MEC_BIT_BIPOLAR_INJ = 6;
   localparam int MEC_BIT_PATTERN_INJ = 5;
   localparam int MEC_BIT_ZERO_DEF = 4;
   localparam int MEC_BIT_SRC_HI = 3;
   localparam int MEC_BIT_SRC_LO = 2;
   localparam int MEC_BIT_MODE = 1;
   localparam int MEC_BIT_XFER = 0;
   localparam int MEC_BIT_TIMER = 1;
   localparam int MEC_BIT_CNT_OV = 0;
   localparam logic [1:0] MEC_SRC_PATTERN = 2'h0;
   localparam logic [1:0] MEC_SRC_ZEROS = 2'h1;
   localparam logic [1:0] MEC_SRC_CODE = 2'h2;
   localparam logic [1:0] MEC_SRC_BOTH = 2'h3;
   localparam logic [15:0] MEC_CNT_MAX = 16'hFFFF;
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mec_reg_req_s;
   typedef struct packed
   {
      logic pattern_error;
      logic excess_zeros;
      logic code_violation;
   } mec_err_evt_s;
endpackage
`default_nettype wire

// ### mec_err_counter.sv
// 16-bit error counter with transfer and overflow event
`timescale 1ns/10ps
`default_nettype none
module mec_err_counter
   import mec_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [1:0] inc,
   input wire logic xfer,
   output logic [15:0] count_result,
   output logic overflow
);
   logic [15:0] count;
   wire [16:0] sum = {1'b0, count} + {15'h0000, inc};
   wire sat = sum[16] | (sum[15:0] == MEC_CNT_MAX);
   wire [15:0] next_count = sat ? MEC_CNT_MAX : sum[15:0];
   // overflow fires once, on reaching the maximum
   wire next_overflow = sat & (count != MEC_CNT_MAX) & ~xfer;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         count <= 16'h0000;
         count_result <= 16'h0000;
         overflow <= 1'b0;
      end
      else
      begin
         // errors of the transfer cycle go into the fresh count
         count <= xfer ? {14'h0000, inc} : next_count;
         if (xfer)
            count_result <= count;
         overflow <= next_overflow;
      end
   end

   AST_OVF_AT_MAX: assert property (@(posedge clk) disable iff (!rstn)
      overflow |-> count == MEC_CNT_MAX)
      else $error("overflow without full counter");
   AST_XFER_CLEARS: assert property (@(posedge clk) disable iff (!rstn)
      xfer |=> count <= 16'h0002 && count_result == $past(count))
      else $error("transfer did not copy and clear");
endmodule
`default_nettype wire

// ### mec_regs.sv
// maintenance, error counter and interrupt mask register group
//Contract
// - deactivate pattern register, default 001001
// - pattern uses low 5 to 8 bits
// - bit6 rise injects one bipolar violation
// - bit5 rise injects one pattern error
// - bit4 picks excess-zero definition
// - bits3-2 choose counted error source
// - bit1 picks manual or automatic report
// - manual bit0 rise transfers, resets counter
// - mask0 bits gate line events
// - mask 0 enables, 1 suppresses; reset 1
// - mask1 bits gate counter, jitter events
// - mask1 bit1 gates one-second timer
// - mask1 bit0 gates counter overflow
// - length field 00-11, resets to 01
// - edge select: rise only, or both
`timescale 1ns/10ps
`default_nettype none
module mec_regs
   import mec_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire mec_reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] line_status,
   input wire logic [7:0] line_edge_sel,
   input wire logic [7:0] aux_events,
   input wire mec_err_evt_s err_evt,
   input wire logic second_tick,
   output logic [7:0] rx_deact_code,
   output logic [1:0] rx_deact_pattern_len,
   output logic bipolar_violation_inject,
   output logic pattern_error_inject,
   output logic excess_zero_definition,
   output logic [7:0] line_irq,
   output logic [7:0] aux_irq
);
   // ***************************************
   // functions
   // ***************************************
   function automatic logic [7:0] len_mask(input logic [1:0] len);
      logic [7:0] m;
      m = 8'h1F;
      case (len)
         2'h1: m = 8'h3F;
         2'h2: m = 8'h7F;
         2'h3: m = 8'hFF;
         default: m = 8'h1F;
      endcase
      return m;
   endfunction

   function automatic logic rising(input logic next_v, input logic cur_v);
      return next_v & ~cur_v;
   endfunction

   // ***************************************
   // registers
   // ***************************************
   logic [7:0] rx_deact_pattern;
   logic [1:0] deact_len;
   logic [7:0] ctrl;
   logic [7:0] mask0;
   logic [7:0] mask1;
   logic [7:0] line_prev;
   logic [15:0] count_result;
   logic cnt_overflow;

   wire wr_deact = reg_req.wr & (reg_req.addr == MEC_OFS_DEACT);
   wire wr_len = reg_req.wr & (reg_req.addr == MEC_OFS_DEACT_LEN);
   wire wr_ctrl = reg_req.wr & (reg_req.addr == MEC_OFS_CTRL);
   wire wr_mask0 = reg_req.wr & (reg_req.addr == MEC_OFS_MASK0);
   wire wr_mask1 = reg_req.wr & (reg_req.addr == MEC_OFS_MASK1);
   wire [7:0] next_ctrl = wr_ctrl ? (reg_req.wdata & MEC_CTRL_WMASK) : ctrl;
   wire [1:0] err_src = ctrl[MEC_BIT_SRC_HI:MEC_BIT_SRC_LO];
   wire auto_mode = ctrl[MEC_BIT_MODE];
   wire manual_xfer = ~auto_mode
      & rising(next_ctrl[MEC_BIT_XFER], ctrl[MEC_BIT_XFER]);
   wire cnt_xfer = manual_xfer | (auto_mode & second_tick);

   // ***************************************
   // error source select
   // ***************************************
   wire src_pat = (err_src == MEC_SRC_PATTERN) & err_evt.pattern_error;
   wire src_zeros = ((err_src == MEC_SRC_ZEROS) | (err_src == MEC_SRC_BOTH))
      & err_evt.excess_zeros;
   wire src_code = ((err_src == MEC_SRC_CODE) | (err_src == MEC_SRC_BOTH))
      & err_evt.code_violation;
   wire [1:0] cnt_inc = {1'b0, src_pat} + {1'b0, src_zeros} + {1'b0, src_code};

   mec_err_counter mec_err_counter_inst
   (
      .clk(clk),
      .rstn(rstn),
      .inc(cnt_inc),
      .xfer(cnt_xfer),
      .count_result(count_result),
      .overflow(cnt_overflow)
   );

   // ***************************************
   // interrupt events
   // ***************************************
   wire [7:0] line_rise = line_status & ~line_prev;
   wire [7:0] line_fall = ~line_status & line_prev;
   wire [7:0] line_evt = line_rise | (line_edge_sel & line_fall);
   wire [7:0] aux_evt = {aux_events[7:1], cnt_overflow};
   wire [7:0] next_line_irq = line_evt & ~mask0;
   wire [7:0] next_aux_irq = aux_evt & ~mask1;

   // ***************************************
   // read mux
   // ***************************************
   logic [7:0] rd_mux;
   always_comb
   begin
      case (reg_req.addr)
         MEC_OFS_DEACT_LEN: rd_mux = {6'h00, deact_len};
         MEC_OFS_DEACT: rd_mux = rx_deact_pattern;
         MEC_OFS_CTRL: rd_mux = ctrl;
         MEC_OFS_MASK0: rd_mux = mask0;
         MEC_OFS_MASK1: rd_mux = mask1;
         MEC_OFS_CNT_LO: rd_mux = count_result[7:0];
         MEC_OFS_CNT_HI: rd_mux = count_result[15:8];
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rx_deact_pattern <= MEC_RST_DEACT;
         deact_len <= MEC_RST_DEACT_LEN;
         ctrl <= MEC_RST_CTRL;
         mask0 <= MEC_RST_MASK;
         mask1 <= MEC_RST_MASK;
         line_prev <= 8'h00;
         reg_rdata <= 8'h00;
         rx_deact_code <= 8'h00;
         rx_deact_pattern_len <= 2'h0;
         bipolar_violation_inject <= 1'b0;
         pattern_error_inject <= 1'b0;
         excess_zero_definition <= 1'b0;
         line_irq <= 8'h00;
         aux_irq <= 8'h00;
      end
      else
      begin
         if (wr_deact)
            rx_deact_pattern <= reg_req.wdata;
         if (wr_len)
            deact_len <= reg_req.wdata[1:0];
         if (wr_mask0)
            mask0 <= reg_req.wdata;
         if (wr_mask1)
            mask1 <= reg_req.wdata;
         ctrl <= next_ctrl;
         line_prev <= line_status;
         if (reg_req.rd)
            reg_rdata <= rd_mux;
         rx_deact_code <= rx_deact_pattern & len_mask(deact_len);
         rx_deact_pattern_len <= deact_len;
         bipolar_violation_inject <= rising(next_ctrl[MEC_BIT_BIPOLAR_INJ],
            ctrl[MEC_BIT_BIPOLAR_INJ]);
         pattern_error_inject <= rising(next_ctrl[MEC_BIT_PATTERN_INJ],
            ctrl[MEC_BIT_PATTERN_INJ]);
         excess_zero_definition <= ctrl[MEC_BIT_ZERO_DEF];
         line_irq <= next_line_irq;
         aux_irq <= next_aux_irq;
      end
   end

   // ***************************************
   // checks
   // ***************************************
   sequence s_bipolar_set;
      wr_ctrl && reg_req.wdata[MEC_BIT_BIPOLAR_INJ] && !ctrl[MEC_BIT_BIPOLAR_INJ];
   endsequence

   AST_BIPOLAR_ONE_SHOT: assert property (@(posedge clk) disable iff (!rstn)
      s_bipolar_set |=> bipolar_violation_inject ##1 !bipolar_violation_inject)
      else $error("bipolar violation not a single pulse");
   AST_BIPOLAR_CAUSE: assert property (@(posedge clk) disable iff (!rstn)
      bipolar_violation_inject |-> $past(ctrl[MEC_BIT_BIPOLAR_INJ]) == 1'b0)
      else $error("bipolar violation without rising bit");
   AST_ERR_ONE_SHOT: assert property (@(posedge clk) disable iff (!rstn)
      pattern_error_inject |-> (!$past(ctrl[MEC_BIT_PATTERN_INJ])
         && ctrl[MEC_BIT_PATTERN_INJ]) ##1 !pattern_error_inject)
      else $error("pattern error inject without rise or held");
   AST_DEACT_LEN: assert property (@(posedge clk) disable iff (!rstn)
      deact_len == 2'h0 ##1 deact_len == 2'h0 |-> rx_deact_code[7:5] == 3'h0)
      else $error("deactivate code wider than length");
   AST_LINE_MASKED: assert property (@(posedge clk) disable iff (!rstn)
      ##1 (line_irq & $past(mask0)) == 8'h00)
      else $error("masked line interrupt raised");
   AST_LINE_RISE: assert property (@(posedge clk) disable iff (!rstn)
      (line_rise[0] && !mask0[0]) |=> line_irq[0])
      else $error("rising status lost");
   AST_FALL_SEL: assert property (@(posedge clk) disable iff (!rstn)
      (line_fall[0] && !line_edge_sel[0]) |=> !line_irq[0])
      else $error("falling edge raised without select");
   AST_CNT_OV_IRQ: assert property (@(posedge clk) disable iff (!rstn)
      (cnt_overflow && !mask1[MEC_BIT_CNT_OV]) |=> aux_irq[MEC_BIT_CNT_OV])
      else $error("counter overflow interrupt lost");
   AST_AUTO_NO_MANUAL: assert property (@(posedge clk) disable iff (!rstn)
      (auto_mode && !second_tick) |-> !cnt_xfer)
      else $error("transfer in auto mode without tick");
endmodule
`default_nettype wire

// ### mec_regs_tb.sv
// self-checking testbench of the maintenance, counter and mask registers
`timescale 1ns/10ps
`default_nettype none
module mec_regs_tb
   import mec_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   mec_reg_req_s reg_req = '0;
   mec_err_evt_s err_evt = '0;
   logic [7:0] line_status = 8'h00;
   logic [7:0] line_edge_sel = 8'h00;
   logic [7:0] aux_events = 8'h00;
   logic second_tick = 1'b0;
   logic [7:0] reg_rdata, rx_deact_code, line_irq, aux_irq, line_or, aux_or;
   logic [1:0] rx_deact_pattern_len;
   logic bipolar_violation_inject, pattern_error_inject, excess_zero_definition;
   logic [15:0] l0_cnt, a0_cnt, bipolar_cnt, per_cnt;
   logic mon_clr = 1'b0;
   logic [7:0] src_exp [4] = '{8'h03, 8'h05, 8'h07, 8'h0C};
   int error_cnt = 0;
   int samples_checked = 0;
   mec_regs mec_regs_inst (.clk(clk), .rstn(rstn), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .line_status(line_status), .line_edge_sel(line_edge_sel),
      .aux_events(aux_events), .err_evt(err_evt), .second_tick(second_tick),
      .rx_deact_code(rx_deact_code), .rx_deact_pattern_len(rx_deact_pattern_len),
      .bipolar_violation_inject(bipolar_violation_inject),
      .pattern_error_inject(pattern_error_inject),
      .excess_zero_definition(excess_zero_definition), .line_irq(line_irq),
      .aux_irq(aux_irq));
   always #5 clk = ~clk;
   // ****************
   // output monitors
   // ****************
   always @(posedge clk)
   begin
      if (mon_clr)
      begin
         line_or <= 8'h00;
         aux_or <= 8'h00;
         l0_cnt <= 16'h0000;
         a0_cnt <= 16'h0000;
         bipolar_cnt <= 16'h0000;
         per_cnt <= 16'h0000;
      end
      else
      begin
         line_or <= line_or | line_irq;
         aux_or <= aux_or | aux_irq;
         l0_cnt <= l0_cnt + 16'(line_irq[0]);
         a0_cnt <= a0_cnt + 16'(aux_irq[0]);
         bipolar_cnt <= bipolar_cnt + 16'(bipolar_violation_inject);
         per_cnt <= per_cnt + 16'(pattern_error_inject);
      end
   end
   // ****************
   // tasks
   // ****************
   task automatic clr();
      mon_clr = 1'b1;
      cyc(1);
      mon_clr = 1'b0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      reg_req.wr = 1'b1;
      reg_req.addr = a;
      reg_req.wdata = d;
      cyc(1);
      reg_req.wr = 1'b0;
      cyc(1);
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      cyc(1);
      reg_req.rd = 1'b0;
      check(16'(reg_rdata), 16'(exp));
      cyc(1);
   endtask
   task automatic errs(input int p, input int e, input int c);
      for (int i = 0; i < 8; i++)
      begin
         err_evt.pattern_error = (i < p);
         err_evt.excess_zeros = (i < e);
         err_evt.code_violation = (i < c);
         cyc(1);
      end
      err_evt = '0;
      cyc(1);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ****************
   // test sequence
   // ****************
   initial
   begin
      clr();
      cyc(7);
      rstn = 1'b1;
      cyc(2);
      rd_reg(MEC_OFS_DEACT, 8'h09);
      rd_reg(MEC_OFS_DEACT_LEN, 8'h01);
      rd_reg(MEC_OFS_CTRL, 8'h00);
      rd_reg(MEC_OFS_MASK0, 8'hFF);
      rd_reg(MEC_OFS_MASK1, 8'hFF);
      check(16'(rx_deact_code), 16'h0009);
      wr_reg(8'h20, 8'hAA);
      rd_reg(8'h20, 8'h00);
      $display("test reset done");
      wr_reg(MEC_OFS_DEACT, 8'hFF);
      for (int l = 0; l < 4; l++)
      begin
         wr_reg(MEC_OFS_DEACT_LEN, {6'h3F, l[1:0]});
         check(16'(rx_deact_code), 16'(8'hFF >> (3 - l)));
         check(16'(rx_deact_pattern_len), 16'(l));
      end
      rd_reg(MEC_OFS_DEACT_LEN, 8'h03);
      $display("test deactivate code done");
      wr_reg(MEC_OFS_CTRL, 8'h90);
      rd_reg(MEC_OFS_CTRL, 8'h10);
      check(16'(excess_zero_definition), 16'h0001);
      wr_reg(MEC_OFS_CTRL, 8'h00);
      check(16'(excess_zero_definition), 16'h0000);
      clr();
      wr_reg(MEC_OFS_CTRL, 8'h40);
      wr_reg(MEC_OFS_CTRL, 8'h40);
      wr_reg(MEC_OFS_CTRL, 8'h00);
      wr_reg(MEC_OFS_CTRL, 8'h60);
      wr_reg(MEC_OFS_CTRL, 8'h20);
      check(bipolar_cnt, 16'h0002);
      check(per_cnt, 16'h0001);
      $display("test injection done");
      wr_reg(MEC_OFS_CTRL, 8'h01);
      for (int s = 0; s < 4; s++)
      begin
         wr_reg(MEC_OFS_CTRL, {4'h0, s[1:0], 2'b00});
         errs(3, 5, 7);
         wr_reg(MEC_OFS_CTRL, {4'h0, s[1:0], 2'b01});
         rd_reg(MEC_OFS_CNT_LO, src_exp[s]);
         rd_reg(MEC_OFS_CNT_HI, 8'h00);
      end
      wr_reg(MEC_OFS_CTRL, 8'h06);
      errs(0, 4, 0);
      wr_reg(MEC_OFS_CTRL, 8'h07);
      rd_reg(MEC_OFS_CNT_LO, 8'h0C);
      second_tick = 1'b1;
      cyc(1);
      second_tick = 1'b0;
      cyc(2);
      rd_reg(MEC_OFS_CNT_LO, 8'h04);
      $display("test counter done");
      wr_reg(MEC_OFS_MASK1, 8'hFE);
      wr_reg(MEC_OFS_CTRL, 8'h00);
      wr_reg(MEC_OFS_CTRL, 8'h01);
      wr_reg(MEC_OFS_CTRL, 8'h00);
      clr();
      err_evt.pattern_error = 1'b1;
      cyc(65540);
      err_evt.pattern_error = 1'b0;
      cyc(3);
      check(a0_cnt, 16'h0001);
      wr_reg(MEC_OFS_CTRL, 8'h01);
      rd_reg(MEC_OFS_CNT_LO, 8'hFF);
      rd_reg(MEC_OFS_CNT_HI, 8'hFF);
      $display("test overflow done");
      // all masked, then only the timer, then all let through
      for (int k = 0; k < 3; k++)
      begin
         wr_reg(MEC_OFS_MASK1, (k == 0) ? 8'hFF : ((k == 1) ? 8'hFD : 8'h00));
         clr();
         aux_events = 8'hFF;
         cyc(1);
         aux_events = 8'h00;
         cyc(3);
         check(16'(aux_or), (k == 0) ? 16'h0000 : ((k == 1) ? 16'h0002 : 16'h00FE));
      end
      wr_reg(MEC_OFS_MASK0, 8'hFE);
      rd_reg(MEC_OFS_MASK0, 8'hFE);
      for (int m = 1; m >= 0; m--)
      begin
         line_edge_sel = m ? 8'hFF : 8'h00;
         clr();
         line_status = 8'hFF;
         cyc(3);
         line_status = 8'h00;
         cyc(3);
         check(l0_cnt, 16'(m + 1));
         check(16'(line_or), 16'h0001);
      end
      $display("test interrupt masks done");
      final_report();
   end
   initial
   begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      final_report();
   end
endmodule
`default_nettype wire
